// file: design/php_defines.vh
// Constants shared by the palette host port and the pixel mapping path
`ifndef PHP_DEFINES_VH
`define PHP_DEFINES_VH
`define PHP_SEL_ADDR   2'b00
`define PHP_SEL_LUT    2'b01
`define PHP_SEL_CTRL   2'b10
`define PHP_SEL_MODE   2'b11
`define PHP_IX_ID      8'h03
`define PHP_IX_MASK    8'h04
`define PHP_IX_CMD1    8'h05
`define PHP_IX_CMD2    8'h06
`define PHP_IX_CMD3    8'h07
`define PHP_MODE_RST   8'hff
`define PHP_CMD1_RST   8'h00
`define PHP_CMD2_RST   8'hff
`define PHP_CMD3_RST   8'hff
`define PHP_MASK_RST   8'hff
`define PHP_MR_SEQ     0
`define PHP_MR_RES     1
`define PHP_MR_BUS     2
`define PHP_CM_HI      7
`define PHP_CM_LO      4
`define PHP_CM_TRUE24  3'b111
`define PHP_CM_TRUE15  3'b110
`define PHP_PS_RED     2'b00
`define PHP_PS_GREEN   2'b01
`define PHP_PRG_HI     1
`define PHP_PRG_LO     0
`define PHP_MUX_HI     7
`define PHP_MUX_LO     6
`define PHP_MUX_4      2'b11
`define PHP_MUX_2      2'b10
`define PHP_POR_NS     1000
`define PHP_CLK_MHZ    200
`endif

// file: design/php_fifo.v
// Pixel FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module php_fifo #(
	parameter WIDTH = 24,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire             in_valid,
	output reg              in_ready_ff,
	input  wire [WIDTH-1:0] in_data,
	output reg              out_valid_ff,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	// Pointers wrap naturally, so DEPTH must equal 2**AW
	localparam [AW:0] FULL = DEPTH;
	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [AW-1:0]    wr_ptr_ff;
	reg  [AW-1:0]    rd_ptr_ff;
	reg  [AW:0]      count_ff;
	wire             push;
	wire             pop;
	wire [AW:0]      nxt_count;

	assign push      = in_valid & in_ready_ff;
	assign pop       = out_valid_ff & out_ready;
	assign nxt_count = count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	assign out_data  = mem[rd_ptr_ff];

	always @(posedge clk) begin
		if (push)
			mem[wr_ptr_ff] <= in_data;
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_ff    <= {AW{1'b0}};
			rd_ptr_ff    <= {AW{1'b0}};
			count_ff     <= {(AW+1){1'b0}};
			in_ready_ff  <= 1'b1;
			out_valid_ff <= 1'b0;
		end else begin
			if (push)
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			if (pop)
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			count_ff     <= nxt_count;
			in_ready_ff  <= (nxt_count != FULL);
			out_valid_ff <= (nxt_count != {(AW+1){1'b0}});
		end
	end
endmodule
`default_nettype wire

// file: design/php_core.v
// Palette host port, colour table and pixel input mapping
`timescale 1ns/1ps
`default_nettype none
`include "php_defines.vh"
// Summary of operation
// - 15-bit mode at 8-bit resolution uses 32 entries of 24 bits.
// - 15-bit modes use only the five low index bits of each table.
// - 24-bit modes index tables directly with red, green and blue inputs.
// - First 15-bit mode takes bits 7..3 of each colour.
// - Second 15-bit mode takes red 7..0 and green 6..0, others ignored.
// - Host port: 10-bit two-way data, strobe low, two selects, read/write.
// - Select 1,0 reaches the control register named by the pointer.
// - Select 0,1 reaches the colour table through colour holding registers.
// - After power-up the host bus is 10 bits wide.
// - Palette write: pointer, then red, green, blue; pointer write restarts at red.
// - Blue write stores joined colours at the pointer, then increments it.
// - Pointer wraps from ff to 00 after blue.
// - Palette read steps red, green, blue, increments and wraps likewise.
// - Mode and pointer are direct; control registers via pointer index.
// - On 8-bit bus, 10-bit value: upper eight bits first, then two low bits.
// - Reset: phase A, mode and command two, three all ones, command one zero.
// - During reset clock output is clock/32 and latch output clock/4.
// - Reset window lasts 1 us; host accesses in it are ignored.
// - Table pointer is eight bits, readable and writable.
// - Mode register is eight bits; top two bits read zero.
// - Writing sequence bit 1, 0, 1 restarts pixel phase at A.
// - Resolution one: 10-bit colours; zero: 8-bit with two low bits zero.
// - Bus width bit picks 10 or 8 bits; 8-bit mode reads top lines zero.
module php_core #(
	parameter [7:0] ID_VALUE   = 8'h5a,
	parameter       FIFO_DEPTH = 16,
	parameter       FIFO_AW    = 4
) (
	input  wire       clk,
	input  wire       rst_n,
	input  wire [9:0] host_data_in,
	output reg  [9:0] host_data_out_ff,
	output reg        host_data_oe_ff,
	input  wire       chip_enable_n,
	input  wire       reg_select_low,
	input  wire       reg_select_high,
	input  wire       read_not_write,
	input  wire [7:0] pixel_red,
	input  wire [7:0] pixel_green,
	input  wire [7:0] pixel_blue,
	input  wire       pixel_valid,
	output wire       pixel_ready,
	output reg  [9:0] dac_red_ff,
	output reg  [9:0] dac_green_ff,
	output reg  [9:0] dac_blue_ff,
	output reg        dac_valid_ff,
	input  wire       dac_ready,
	output reg  [1:0] pixel_phase_ff,
	output reg        programmable_clock_out_ff,
	output reg        pixel_latch_clock_out_ff,
	output reg        device_ready_ff
);
	// ID_VALUE is arbitrary
	localparam integer POR_CYC = (`PHP_POR_NS * `PHP_CLK_MHZ + 999) / 1000;
	localparam [8:0]   POR_LOAD = POR_CYC[8:0];
	localparam         SB_CE = 13;
	localparam         SB_RW = 12;
	localparam [1:0]   SUB_R = 2'd0;
	localparam [1:0]   SUB_G = 2'd1;
	localparam [1:0]   SUB_B = 2'd2;
	localparam [1:0]   SQ_IDLE = 2'd0;
	localparam [1:0]   SQ_ONE = 2'd1;
	localparam [1:0]   SQ_ZERO = 2'd2;

	reg  [13:0] sync1_ff;
	reg  [13:0] sync2_ff;
	reg  [13:0] sync3_ff;
	reg         ce_acc_ff;
	reg  [8:0]  por_cnt_ff;
	reg  [7:0]  pointer_ff;
	reg  [7:0]  mode_ff;
	reg  [7:0]  cmd1_ff;
	reg  [7:0]  cmd2_ff;
	reg  [7:0]  cmd3_ff;
	reg  [7:0]  mask_ff;
	reg  [1:0]  sub_ff;
	reg         half_ff;
	reg  [7:0]  hold_hi_ff;
	reg  [9:0]  red_hold_ff;
	reg  [9:0]  green_hold_ff;
	reg  [1:0]  seq_st_ff;
	reg         restart_ff;
	reg  [4:0]  div_ff;
	reg  [9:0]  red_lut [0:255];
	reg  [9:0]  green_lut [0:255];
	reg  [9:0]  blue_lut [0:255];
	reg  [9:0]  rd_r_ff;
	reg  [9:0]  rd_g_ff;
	reg  [9:0]  rd_b_ff;
	reg  [7:0]  ctrl_rd;
	reg  [9:0]  rval;
	reg  [7:0]  ir;
	reg  [7:0]  ig;
	reg  [7:0]  ib;
	reg  [7:0]  pseudo;
	wire        ce_new;
	wire        por_busy;
	wire        start;
	wire        finish;
	wire [9:0]  d;
	wire [1:0]  sel;
	wire        rd;
	wire        res10;
	wire        bus8;
	wire        wide;
	wire [9:0]  cur;
	wire [9:0]  wval;
	wire        lut_we;
	wire        fifo_valid;
	wire [23:0] fifo_data;
	wire        take;
	wire [7:0]  m_r;
	wire [7:0]  m_g;
	wire [7:0]  m_b;
	wire [2:0]  cm_top;
	wire [1:0]  mux;

	// Strobe change is accepted only once stages two and three agree
	assign ce_new   = (sync2_ff[SB_CE] == sync3_ff[SB_CE]) ? sync3_ff[SB_CE] : ce_acc_ff;
	assign por_busy = (por_cnt_ff != 9'h000);
	assign start    = ce_acc_ff & ~ce_new & ~por_busy;
	assign finish   = ~ce_acc_ff & ce_new;
	assign d        = sync3_ff[9:0];
	assign sel      = sync3_ff[11:10];
	assign rd       = sync3_ff[SB_RW];
	assign res10    = mode_ff[`PHP_MR_RES];
	assign bus8     = ~mode_ff[`PHP_MR_BUS];
	assign wide     = res10 & bus8;
	assign cur      = (sub_ff == SUB_R) ? rd_r_ff : ((sub_ff == SUB_G) ? rd_g_ff : rd_b_ff);
	assign wval     = res10 ? (bus8 ? {hold_hi_ff, d[1:0]} : d) : {d[7:0], 2'b00};
	assign lut_we   = start & (sel == `PHP_SEL_LUT) & ~rd & ~(wide & ~half_ff) & (sub_ff == SUB_B);

	always @* begin
		case (pointer_ff)
		`PHP_IX_ID:   ctrl_rd = ID_VALUE;
		`PHP_IX_MASK: ctrl_rd = mask_ff;
		`PHP_IX_CMD1: ctrl_rd = cmd1_ff;
		`PHP_IX_CMD2: ctrl_rd = cmd2_ff;
		`PHP_IX_CMD3: ctrl_rd = cmd3_ff;
		default:      ctrl_rd = 8'h00;
		endcase
	end

	always @* begin
		case (sel)
		`PHP_SEL_ADDR: rval = {2'b00, pointer_ff};
		`PHP_SEL_MODE: rval = {2'b00, mode_ff};
		`PHP_SEL_CTRL: rval = {2'b00, ctrl_rd};
		default: begin
			if (wide & half_ff)
				rval = {8'h00, cur[1:0]};
			else if (res10 & ~wide)
				rval = cur;
			else
				rval = {2'b00, cur[9:2]};
		end
		endcase
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_ff   <= 14'h3fff;
			sync2_ff   <= 14'h3fff;
			sync3_ff   <= 14'h3fff;
			ce_acc_ff  <= 1'b1;
			por_cnt_ff <= POR_LOAD;
			device_ready_ff <= 1'b0;
		end else begin
			sync1_ff   <= {chip_enable_n, read_not_write, reg_select_high,
				reg_select_low, host_data_in};
			sync2_ff   <= sync1_ff;
			sync3_ff   <= sync2_ff;
			ce_acc_ff  <= ce_new;
			if (por_busy)
				por_cnt_ff <= por_cnt_ff - 9'h001;
			device_ready_ff <= ~por_busy;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pointer_ff       <= 8'h00;
			mode_ff          <= `PHP_MODE_RST;
			cmd1_ff          <= `PHP_CMD1_RST;
			cmd2_ff          <= `PHP_CMD2_RST;
			cmd3_ff          <= `PHP_CMD3_RST;
			mask_ff          <= `PHP_MASK_RST;
			sub_ff           <= SUB_R;
			half_ff          <= 1'b0;
			hold_hi_ff       <= 8'h00;
			red_hold_ff      <= 10'h000;
			green_hold_ff    <= 10'h000;
			seq_st_ff        <= SQ_IDLE;
			restart_ff       <= 1'b0;
			host_data_out_ff <= 10'h000;
			host_data_oe_ff  <= 1'b0;
		end else begin
			restart_ff <= 1'b0;
			if (finish)
				host_data_oe_ff <= 1'b0;
			if (start && rd) begin
				host_data_out_ff <= bus8 ? {2'b00, rval[7:0]} : rval;
				host_data_oe_ff  <= 1'b1;
			end
			if (start) begin
				case (sel)
				`PHP_SEL_ADDR: if (!rd) begin
					pointer_ff <= d[7:0];
					sub_ff     <= SUB_R;
					half_ff    <= 1'b0;
				end
				`PHP_SEL_MODE: if (!rd) begin
					mode_ff <= d[7:0];
					// Sequence bit must see 1, 0, 1 before pixel phase restarts
					case (seq_st_ff)
					SQ_IDLE:
						if (d[`PHP_MR_SEQ])
							seq_st_ff <= SQ_ONE;
					SQ_ONE:
						if (!d[`PHP_MR_SEQ])
							seq_st_ff <= SQ_ZERO;
					SQ_ZERO:
						if (d[`PHP_MR_SEQ]) begin
							seq_st_ff  <= SQ_ONE;
							restart_ff <= 1'b1;
						end
					default: seq_st_ff <= SQ_IDLE;
					endcase
				end
				`PHP_SEL_CTRL: if (!rd) begin
					case (pointer_ff)
					`PHP_IX_MASK: mask_ff <= d[7:0];
					`PHP_IX_CMD1: cmd1_ff <= d[7:0];
					`PHP_IX_CMD2: cmd2_ff <= d[7:0];
					`PHP_IX_CMD3: cmd3_ff <= d[7:0];
					default: ;
					endcase
				end
				default: begin
					if (wide && !half_ff) begin
						half_ff    <= 1'b1;
						hold_hi_ff <= d[7:0];
					end else begin
						half_ff <= 1'b0;
						if (!rd && sub_ff == SUB_R)
							red_hold_ff <= wval;
						if (!rd && sub_ff == SUB_G)
							green_hold_ff <= wval;
						if (sub_ff == SUB_B) begin
							sub_ff     <= SUB_R;
							pointer_ff <= pointer_ff + 8'h01;
						end else begin
							sub_ff <= sub_ff + 2'd1;
						end
					end
				end
				endcase
			end
		end
	end

	// Table read for the host is prefetched at the pointer every cycle
	always @(posedge clk) begin
		if (lut_we) begin
			red_lut[pointer_ff]   <= red_hold_ff;
			green_lut[pointer_ff] <= green_hold_ff;
			blue_lut[pointer_ff]  <= wval;
		end
		rd_r_ff <= red_lut[pointer_ff];
		rd_g_ff <= green_lut[pointer_ff];
		rd_b_ff <= blue_lut[pointer_ff];
	end

	php_fifo #(.WIDTH(24), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
		.clk          (clk),
		.rst_n        (rst_n),
		.in_valid     (pixel_valid),
		.in_ready_ff  (pixel_ready),
		.in_data      ({pixel_red, pixel_green, pixel_blue}),
		.out_valid_ff (fifo_valid),
		.out_ready    (take),
		.out_data     (fifo_data)
	);

	assign take   = fifo_valid & (~dac_valid_ff | dac_ready);
	assign m_r    = fifo_data[23:16] & mask_ff;
	assign m_g    = fifo_data[15:8] & mask_ff;
	assign m_b    = fifo_data[7:0] & mask_ff;
	assign cm_top = cmd2_ff[`PHP_CM_HI:`PHP_CM_LO+1];
	assign mux    = cmd3_ff[`PHP_MUX_HI:`PHP_MUX_LO];

	always @* begin
		case (cm_top[2:1])
		`PHP_PS_RED:   pseudo = m_r;
		`PHP_PS_GREEN: pseudo = m_g;
		default:       pseudo = m_b;
		endcase
		if (cm_top == `PHP_CM_TRUE24) begin
			ir = m_r;
			ig = m_g;
			ib = m_b;
		end else if (cm_top == `PHP_CM_TRUE15 && !cmd2_ff[`PHP_CM_LO]) begin
			ir = {3'b000, m_r[7:3]};
			ig = {3'b000, m_g[7:3]};
			ib = {3'b000, m_b[7:3]};
		end else if (cm_top == `PHP_CM_TRUE15) begin
			ir = {3'b000, m_r[7:3]};
			ig = {3'b000, m_r[2:0], m_g[6:5]};
			ib = {3'b000, m_g[4:0]};
		end else begin
			ir = pseudo;
			ig = pseudo;
			ib = pseudo;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dac_red_ff     <= 10'h000;
			dac_green_ff   <= 10'h000;
			dac_blue_ff    <= 10'h000;
			dac_valid_ff   <= 1'b0;
			pixel_phase_ff <= 2'd0;
		end else begin
			if (take) begin
				dac_red_ff   <= res10 ? red_lut[ir] : {red_lut[ir][9:2], 2'b00};
				dac_green_ff <= res10 ? green_lut[ig] : {green_lut[ig][9:2], 2'b00};
				dac_blue_ff  <= res10 ? blue_lut[ib] : {blue_lut[ib][9:2], 2'b00};
				dac_valid_ff <= 1'b1;
			end else if (dac_ready)
				dac_valid_ff <= 1'b0;
			if (restart_ff)
				pixel_phase_ff <= 2'd0;
			else if (take && mux == `PHP_MUX_4)
				pixel_phase_ff <= pixel_phase_ff + 2'd1;
			else if (take && mux == `PHP_MUX_2)
				pixel_phase_ff <= {1'b0, ~pixel_phase_ff[0]};
			else if (take)
				pixel_phase_ff <= 2'd0;
		end
	end

	// One free counter feeds both clocks so their falling edges coincide.
	// Single multiplex rate cannot run at clk from a flop; it falls back to /2.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_ff                    <= 5'h00;
			programmable_clock_out_ff <= 1'b0;
			pixel_latch_clock_out_ff  <= 1'b0;
		end else begin
			div_ff <= div_ff + 5'h01;
			case (cmd3_ff[`PHP_PRG_HI:`PHP_PRG_LO])
			2'b00:   programmable_clock_out_ff <= div_ff[1];
			2'b01:   programmable_clock_out_ff <= div_ff[2];
			2'b10:   programmable_clock_out_ff <= div_ff[3];
			default: programmable_clock_out_ff <= div_ff[4];
			endcase
			pixel_latch_clock_out_ff <= (mux == `PHP_MUX_4) ? div_ff[1] : div_ff[0];
		end
	end
endmodule
`default_nettype wire

// file: sim/php_host_model.sv
// Host bus master model driving the palette host port pins
`timescale 1ns/1ps
`default_nettype none
module php_host_model (
	input  wire logic       clk,
	input  wire logic [9:0] dev_out,
	input  wire logic       dev_oe,
	output var  logic [9:0] bus_in,
	output var  logic       ce_n,
	output var  logic       sel_lo,
	output var  logic       sel_hi,
	output var  logic       rnw
);
	logic [9:0] drv;
	logic       own;

	initial begin
		{ce_n, drv, own} = {1'h1, 10'h000, 1'h0};
		{sel_hi, sel_lo, rnw} = 3'h1;
	end

	// A bus nobody drives shows the inverse of drv, the host's last data word, never a held value
	always @* bus_in = dev_oe ? dev_out : (own ? drv : ~drv);

	// Pins settle 4 cycles before the strobe; strobe low 8 cycles, then high at least 10
	task automatic acc(input logic [1:0] sel, input logic rd, input logic [9:0] wd,
		output logic [9:0] q);
		@(posedge clk) #1;
		{sel_hi, sel_lo} = sel;
		rnw = rd;
		drv = wd;
		own = !rd;
		repeat (4) @(posedge clk);
		#1 ce_n = 1'h0;
		repeat (8) @(posedge clk);
		q = bus_in;
		#1 ce_n = 1'h1;
		repeat (6) @(posedge clk);
		#1 own = 1'h0;
	endtask
endmodule
`default_nettype wire

// file: sim/php_core_assertions.sv
// Concurrent checks on the palette host port and pixel path
`timescale 1ns/1ps
`default_nettype none
module php_core_assertions #(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [9:0] host_data_out_ff,
	input wire logic       host_data_oe_ff,
	input wire logic       chip_enable_n,
	input wire logic       read_not_write,
	input wire logic       pixel_valid,
	input wire logic       pixel_ready,
	input wire logic [9:0] dac_red_ff,
	input wire logic       dac_valid_ff,
	input wire logic       dac_ready,
	input wire logic [1:0] pixel_phase_ff,
	input wire logic       programmable_clock_out_ff,
	input wire logic       pixel_latch_clock_out_ff,
	input wire logic       device_ready_ff
);
	logic [7:0] up_ff;
	logic [5:0] hi_ff;
	logic [5:0] fly_ff;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Cycles since reset, clock output high time, and words taken at the pixel input and not yet handed on
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			up_ff <= 8'h00;
			hi_ff <= 6'h00;
			fly_ff <= 6'h00;
		end else begin
			up_ff <= (up_ff == 8'hff) ? up_ff : up_ff + 8'h01;
			hi_ff <= programmable_clock_out_ff ? hi_ff + 6'h01 : 6'h00;
			fly_ff <= fly_ff + 6'(pixel_valid && pixel_ready) - 6'(dac_valid_ff && dac_ready);
		end
	end

	property p_oe_read;
		$rose(host_data_oe_ff) |-> read_not_write && !chip_enable_n;
	endproperty
	a_oe_read: assert property (p_oe_read) else $error("bus driven without a read");
	property p_oe_ready;
		host_data_oe_ff |-> device_ready_ff;
	endproperty
	a_oe_ready: assert property (p_oe_ready) else $error("bus driven in reset window");
	property p_oe_drop;
		$rose(chip_enable_n) |-> ##[1:8] !host_data_oe_ff;
	endproperty
	a_oe_drop: assert property (p_oe_drop) else $error("bus kept after strobe");
	property p_data_hold;
		host_data_oe_ff && $past(host_data_oe_ff) |-> $stable(host_data_out_ff);
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("read data moved");
	property p_ready_time;
		$rose(device_ready_ff) |-> up_ff >= 8'd195 && up_ff <= 8'd205;
	endproperty
	a_ready_time: assert property (p_ready_time) else $error("reset window length");
	property p_phase_por;
		!$past(rst_n) |-> pixel_phase_ff == 2'h0;
	endproperty
	a_phase_por: assert property (p_phase_por) else $error("phase not first");
	property p_prg_div;
		$fell(programmable_clock_out_ff) |-> hi_ff == 6'd16;
	endproperty
	a_prg_div: assert property (p_prg_div) else $error("clock out not divide by 32");
	property p_lat_div;
		$rose(pixel_latch_clock_out_ff) |=> pixel_latch_clock_out_ff
			##1 !pixel_latch_clock_out_ff [*2] ##1 pixel_latch_clock_out_ff;
	endproperty
	a_lat_div: assert property (p_lat_div) else $error("latch out not divide by 4");
	property p_dac_hold;
		dac_valid_ff && !dac_ready |=> dac_valid_ff && $stable(dac_red_ff);
	endproperty
	a_dac_hold: assert property (p_dac_hold) else $error("output word dropped");
	property p_dac_cause;
		fly_ff == 6'd0 |-> !dac_valid_ff && pixel_ready;
	endproperty
	a_dac_cause: assert property (p_dac_cause) else $error("output without input");
	// Buffer plus the output register bound what may be in flight
	property p_fly_max;
		fly_ff <= 6'(FIFO_DEPTH + 1);
	endproperty
	a_fly_max: assert property (p_fly_max) else $error("more words held than room");

	c_read: cover property ($rose(host_data_oe_ff));
	c_full: cover property (!pixel_ready);
	c_stall: cover property (dac_valid_ff && !dac_ready);
endmodule
bind php_core php_core_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.clk, .rst_n,
	.host_data_out_ff, .host_data_oe_ff, .chip_enable_n, .read_not_write, .pixel_valid,
	.pixel_ready, .dac_red_ff, .dac_valid_ff, .dac_ready, .pixel_phase_ff,
	.programmable_clock_out_ff, .pixel_latch_clock_out_ff, .device_ready_ff);
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the palette host port and pixel mapping
`timescale 1ns/1ps
`default_nettype none
`include "php_defines.vh"
module tb_top;
	localparam logic [7:0] IDV = 8'h3c; // Arbitrary identification value
	logic       clk, rst_n, pv, dr, oe, ce_n, slo, shi, rnw, prdy, dval, drdy;
	logic [7:0] pr, pg, pb;
	logic [9:0] bin, dout, dred, dgrn, dblu;
	logic [1:0] ph;
	logic [9:0] color_lookup_table [0:8] = '{10'h123, 10'h2a5, 10'h3c0, 10'h011, 10'h3ff, 10'h200,
		10'h155, 10'h0aa, 10'h301};
	logic [9:0] v [0:2] = '{10'h2d7, 10'h001, 10'h3fe};
	int         fails = 0;
	int         checks = 0;
	int         cyc = 0;

	php_core #(.ID_VALUE(IDV)) dut (.clk(clk), .rst_n(rst_n), .host_data_in(bin),
		.host_data_out_ff(dout), .host_data_oe_ff(oe), .chip_enable_n(ce_n),
		.reg_select_low(slo), .reg_select_high(shi), .read_not_write(rnw),
		.pixel_red(pr), .pixel_green(pg), .pixel_blue(pb), .pixel_valid(pv),
		.pixel_ready(prdy), .dac_red_ff(dred), .dac_green_ff(dgrn), .dac_blue_ff(dblu),
		.dac_valid_ff(dval), .dac_ready(dr), .pixel_phase_ff(ph),
		.programmable_clock_out_ff(), .pixel_latch_clock_out_ff(),
		.device_ready_ff(drdy));
	php_host_model hm (.clk(clk), .dev_out(dout), .dev_oe(oe), .bus_in(bin), .ce_n(ce_n),
		.sel_lo(slo), .sel_hi(shi), .rnw(rnw));

	task automatic chk(input logic [29:0] got, input logic [29:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d, fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wr(input logic [1:0] s, input logic [9:0] d);
		logic [9:0] q;
		hm.acc(s, 1'h0, d, q);
	endtask
	task automatic rdc(input logic [1:0] s, input logic [9:0] e);
		logic [9:0] q;
		hm.acc(s, 1'h1, 10'h000, q);
		chk(30'(q), 30'(e));
	endtask
	task automatic ctl(input logic [7:0] ix, input logic [9:0] e);
		wr(`PHP_SEL_ADDR, 10'(ix));
		rdc(`PHP_SEL_CTRL, e);
	endtask
	task automatic px(input logic [23:0] p, input logic [29:0] e);
		int n;
		{pr, pg, pb} = p;
		pv = 1'h1;
		while (prdy !== 1'h1)
			@(posedge clk) #1;
		@(posedge clk) #1;
		pv = 1'h0;
		for (n = 0; n < 20 && dval !== 1'h1; n++)
			@(posedge clk) #1;
		chk({dred, dgrn, dblu}, e);
	endtask

	task automatic t_reset;
		int n;
		for (n = 0; n < 300 && drdy !== 1'h1; n++)
			@(posedge clk) #1;
		chk(30'(n > 190), 30'h1);
		rdc(`PHP_SEL_MODE, 10'h0ff);
		ctl(`PHP_IX_CMD1, 10'h000);
		ctl(`PHP_IX_CMD2, 10'h0ff);
		ctl(`PHP_IX_CMD3, 10'h0ff);
		ctl(`PHP_IX_ID, {2'h0, IDV});
		wr(`PHP_SEL_ADDR, 10'h0a5);
		rdc(`PHP_SEL_ADDR, 10'h0a5);
		$display("reset test done");
	endtask
	task automatic t_palette;
		wr(`PHP_SEL_ADDR, 10'h0fe);
		for (int i = 0; i < 6; i++)
			wr(`PHP_SEL_LUT, color_lookup_table[i]);
		rdc(`PHP_SEL_ADDR, 10'h000);
		wr(`PHP_SEL_ADDR, 10'h0fe);
		for (int i = 0; i < 6; i++)
			rdc(`PHP_SEL_LUT, color_lookup_table[i]);
		rdc(`PHP_SEL_ADDR, 10'h000);
		wr(`PHP_SEL_ADDR, 10'h01f);
		wr(`PHP_SEL_LUT, 10'h3ff);
		wr(`PHP_SEL_ADDR, 10'h01f);
		for (int i = 6; i < 9; i++)
			wr(`PHP_SEL_LUT, color_lookup_table[i]);
		wr(`PHP_SEL_ADDR, 10'h01f);
		for (int i = 6; i < 9; i++)
			rdc(`PHP_SEL_LUT, color_lookup_table[i]);
		$display("palette test done");
	endtask
	task automatic t_pixel;
		px(24'hfefffe, {color_lookup_table[0], color_lookup_table[4], color_lookup_table[2]});
		wr(`PHP_SEL_ADDR, 10'(`PHP_IX_CMD2));
		wr(`PHP_SEL_CTRL, 10'h0cf);
		px(24'hf8fffb, {color_lookup_table[6], color_lookup_table[7], color_lookup_table[8]});
		wr(`PHP_SEL_CTRL, 10'h0df);
		px(24'hff7fff, {color_lookup_table[6], color_lookup_table[7], color_lookup_table[8]});
		wr(`PHP_SEL_CTRL, 10'h00f);
		px(24'h1f0000, {color_lookup_table[6], color_lookup_table[7], color_lookup_table[8]});
		wr(`PHP_SEL_CTRL, 10'h0cf);
		wr(`PHP_SEL_MODE, 10'h0fd);
		wr(`PHP_SEL_ADDR, 10'h01f);
		wr(`PHP_SEL_LUT, 10'h056);
		wr(`PHP_SEL_LUT, 10'h09a);
		wr(`PHP_SEL_LUT, 10'h0c3);
		px(24'hf8f8f8, {10'h158, 10'h268, 10'h30c});
		wr(`PHP_SEL_MODE, 10'h0fc);
		wr(`PHP_SEL_MODE, 10'h0fd);
		chk(30'(ph), 30'h0);
		$display("pixel test done");
	endtask
	task automatic t_bus8;
		wr(`PHP_SEL_MODE, 10'h0fb);
		wr(`PHP_SEL_ADDR, 10'h040);
		for (int i = 0; i < 3; i++) begin
			wr(`PHP_SEL_LUT, {2'h0, v[i][9:2]});
			wr(`PHP_SEL_LUT, {8'h00, v[i][1:0]});
		end
		wr(`PHP_SEL_ADDR, 10'h040);
		for (int i = 0; i < 3; i++) begin
			rdc(`PHP_SEL_LUT, {2'h0, v[i][9:2]});
			rdc(`PHP_SEL_LUT, {8'h00, v[i][1:0]});
		end
		$display("narrow bus test done");
	endtask
	task automatic t_fifo;
		int n;
		int m;
		n = 0;
		m = 0;
		dr = 1'h0;
		pv = 1'h1;
		while (prdy === 1'h1 && n < 40) begin
			@(posedge clk) #1;
			n++;
		end
		pv = 1'h0;
		chk(30'(n >= 16), 30'h1);
		dr = 1'h1;
		repeat (60) begin
			if (dval === 1'h1)
				m++;
			@(posedge clk) #1;
		end
		chk(30'(m), 30'(n));
		$display("buffer test done");
	endtask

	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	// Whole run is near 1500 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			tally_and_finish();
		end
	end
	initial begin
		{rst_n, pv, dr, pr, pg, pb} = '0;
		repeat (5) @(posedge clk);
		#1 rst_n = 1'h1;
		dr = 1'h1;
		t_reset();
		t_palette();
		t_pixel();
		t_bus8();
		t_fifo();
		tally_and_finish();
	end
endmodule
`default_nettype wire
